// ===== hw/hcirq_pkg.sv
package hcirq_pkg;

  // Register port geometry.
  localparam int unsigned HCIRQ_ADDR_W = 8;
  localparam int unsigned HCIRQ_DATA_W = 32;
  localparam int unsigned HCIRQ_BE_W = 4;
  localparam logic [7:0] HCIRQ_OFS_FLAGS = 8'h0C;

  // Event flag register layout.
  localparam int unsigned HCIRQ_BIT_OVERRUN = 0;
  localparam int unsigned HCIRQ_BIT_DONE = 1;
  localparam int unsigned HCIRQ_BIT_FRAME = 2;
  localparam int unsigned HCIRQ_BIT_WAKE = 3;
  localparam int unsigned HCIRQ_BIT_FATAL = 4;
  localparam int unsigned HCIRQ_BIT_WRAP = 5;
  localparam int unsigned HCIRQ_BIT_HUB = 6;
  localparam int unsigned HCIRQ_BIT_OWNER = 30;
  localparam int unsigned HCIRQ_BIT_GATE = 31;
  localparam logic [31:0] HCIRQ_FLAGS_RST = 32'h0000_0000;
  localparam logic [31:0] HCIRQ_FLAGS_IMPL = 32'h4000_007F;

  // Overrun tally in the command state register, bits 17 to 16.
  localparam int unsigned HCIRQ_TALLY_W = 2;
  localparam logic [1:0] HCIRQ_TALLY_RST = 2'h0;
  localparam logic [1:0] HCIRQ_TALLY_INC = 2'h1;

  // Root hub geometry and frame counter width.
  localparam int unsigned HCIRQ_HUB_PORTS = 2;
  localparam int unsigned HCIRQ_HUB_W = 32;
  localparam int unsigned HCIRQ_FRAME_W = 16;
  localparam int unsigned HCIRQ_FRAME_MSB = 15;

  // Fatal error halt sequencer.
  typedef enum logic [1:0] {
    HCIRQ_RUN,
    HCIRQ_HALTED,
    HCIRQ_RECOVER
  } hcirq_halt_e;

endpackage

// ===== hw/hcirq_sync_rise.sv
`timescale 1ns/1ns
module hcirq_sync_rise (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Asynchronous level in
  input wire logic async_i,
  // Synchronised level and its rising edge
  output logic level_o,
  output logic rise_o
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign level_o = sync_ff;
  assign rise_o = sync_ff & ~last_ff;

endmodule

// ===== hw/hcirq_flags.sv
`timescale 1ns/1ns
module hcirq_flags #(
  parameter bit SMI_PRESENT = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [hcirq_pkg::HCIRQ_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [hcirq_pkg::HCIRQ_BE_W-1:0] reg_be_i,
  input wire logic [hcirq_pkg::HCIRQ_DATA_W-1:0] reg_wdata_i,
  output logic [hcirq_pkg::HCIRQ_DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Enable mask held elsewhere, master gate in bit 31
  input wire logic [hcirq_pkg::HCIRQ_DATA_W-1:0] irq_enable_mask_i,
  // Command state register inputs
  input wire logic owner_switch_request_i,
  input wire logic hc_soft_reset_i,
  // Root hub state
  input wire logic [hcirq_pkg::HCIRQ_HUB_W-1:0] hub_global_state_i,
  input wire logic [hcirq_pkg::HCIRQ_HUB_PORTS*hcirq_pkg::HCIRQ_HUB_W-1:0] hub_port_state_i,
  // Frame engine
  input wire logic [hcirq_pkg::HCIRQ_FRAME_W-1:0] frame_counter_i,
  input wire logic frame_copy_updated_i,
  input wire logic sof_token_i,
  input wire logic sched_overrun_i,
  // List engine
  input wire logic done_pointer_written_i,
  output logic done_write_allow_o,
  // System error and wake
  input wire logic sys_error_i,
  input wire logic wake_signal_pin_i,
  input wire logic wake_signaling_state_i,
  // Outputs
  output logic proc_halt_o,
  output logic [hcirq_pkg::HCIRQ_TALLY_W-1:0] overrun_tally_o,
  output logic [hcirq_pkg::HCIRQ_DATA_W-1:0] irq_event_flags_o,
  output logic irq_o,
  output logic sys_mgmt_irq_pin_o
);
  import hcirq_pkg::*;

  logic [HCIRQ_DATA_W-1:0] flags_ff;
  logic [HCIRQ_DATA_W-1:0] nxt_flags;
  logic [HCIRQ_DATA_W-1:0] set_vec;
  logic [HCIRQ_DATA_W-1:0] clr_vec;
  logic [HCIRQ_DATA_W-1:0] lane_mask;
  logic [HCIRQ_TALLY_W-1:0] tally_ff;
  logic [HCIRQ_TALLY_W-1:0] nxt_tally;
  logic [HCIRQ_HUB_W-1:0] hub_global_last_ff;
  logic [HCIRQ_HUB_PORTS*HCIRQ_HUB_W-1:0] hub_port_last_ff;
  logic [HCIRQ_HUB_PORTS-1:0] port_changed;
  logic hub_primed_ff;
  logic frame_msb_last_ff;
  logic wrap_pending_ff;
  logic overrun_pending_ff;
  logic owner_req_last_ff;
  logic [HCIRQ_DATA_W-1:0] rdata_ff;
  logic rvalid_ff;
  hcirq_halt_e halt_state_ff;
  hcirq_halt_e nxt_halt_state;

  logic wake_level;
  logic wake_rise;
  logic hit_flags;
  logic wr_flags;
  logic rd_flags;
  logic global_changed;
  logic hub_change_evt;
  logic msb_toggle;
  logic wrap_evt;
  logic overrun_evt;
  logic owner_evt;
  logic wake_evt;
  logic frame_evt;
  logic done_evt;
  logic fatal_evt;
  logic master_gate;
  logic [HCIRQ_DATA_W-1:0] pending_vec;
  logic [HCIRQ_DATA_W-1:0] irq_src_vec;

  // The resume pin comes from the line state and so crosses domains.
  hcirq_sync_rise u_wake_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(wake_signal_pin_i),
    .level_o(wake_level),
    .rise_o(wake_rise)
  );

  // Address decoding of the register port.
  assign hit_flags = (reg_addr_i == HCIRQ_OFS_FLAGS);
  assign wr_flags = reg_wr_i & hit_flags;
  assign rd_flags = reg_rd_i & hit_flags;

  // Byte lanes that take part in a write; a lane whose enable is low
  // leaves all of its flags untouched even if its data is all ones.
  localparam int unsigned LANE_W = HCIRQ_DATA_W / HCIRQ_BE_W;
  genvar gl;
  generate
    for (gl = 0; gl < HCIRQ_BE_W; gl++) begin : g_lane
      assign lane_mask[gl*LANE_W +: LANE_W] = {LANE_W{reg_be_i[gl]}};
    end
  endgenerate

  // Only ones written into implemented bits clear; zeros keep the bit.
  // Reserved positions are masked, so stray ones there do nothing.
  assign clr_vec = wr_flags ? (reg_wdata_i & lane_mask & HCIRQ_FLAGS_IMPL) :
                   HCIRQ_FLAGS_RST;

  // Root hub change: compare every state word with its last value.
  // Comparing whole words costs flops but needs no knowledge of the
  // field layout of the port status words.
  assign global_changed = (hub_global_state_i != hub_global_last_ff);

  genvar gp;
  generate
    for (gp = 0; gp < HCIRQ_HUB_PORTS; gp++) begin : g_port
      assign port_changed[gp] =
        (hub_port_state_i[gp*HCIRQ_HUB_W +: HCIRQ_HUB_W] !=
         hub_port_last_ff[gp*HCIRQ_HUB_W +: HCIRQ_HUB_W]);
    end
  endgenerate

  // The first sampled value after reset is a baseline, not a change.
  assign hub_change_evt = hub_primed_ff & (global_changed | (|port_changed));

  // Frame counter wrap is reported once the frame copy has landed.
  // The counter may leave reset with its top bit high, so the first cycle
  // after reset only records a baseline, as for the hub words.
  assign msb_toggle = hub_primed_ff & (frame_counter_i[HCIRQ_FRAME_MSB] ^ frame_msb_last_ff);
  assign wrap_evt = frame_copy_updated_i & (wrap_pending_ff | msb_toggle);

  // Overrun is likewise reported after the frame copy update.
  assign overrun_evt = frame_copy_updated_i & (overrun_pending_ff | sched_overrun_i);

  // Ownership switch follows the request bit going from clear to set.
  // A request held high sets the flag once only; a second switch needs
  // the request to drop and rise again.
  assign owner_evt = SMI_PRESENT & owner_switch_request_i & ~owner_req_last_ff;

  // Resume signaling onset from a device, not the one software asked for.
  // The software resume state is seen in the detect cycle, after the pin
  // synchroniser; a state change inside that gap is not filtered.
  assign wake_evt = wake_rise & ~wake_signaling_state_i;

  assign frame_evt = sof_token_i;
  assign done_evt = done_pointer_written_i;
  assign fatal_evt = sys_error_i;

  // Every event drives only its own bit position.
  always_comb begin
    set_vec = HCIRQ_FLAGS_RST;
    set_vec[HCIRQ_BIT_OVERRUN] = overrun_evt;
    set_vec[HCIRQ_BIT_DONE] = done_evt;
    set_vec[HCIRQ_BIT_FRAME] = frame_evt;
    set_vec[HCIRQ_BIT_WAKE] = wake_evt;
    set_vec[HCIRQ_BIT_FATAL] = fatal_evt;
    set_vec[HCIRQ_BIT_WRAP] = wrap_evt;
    set_vec[HCIRQ_BIT_HUB] = hub_change_evt;
    set_vec[HCIRQ_BIT_OWNER] = owner_evt;
  end

  // A set arriving with its clear wins, so no event is lost.
  // The set term comes from hardware only, so a write cannot set a bit.
  // No hardware term ever clears; only the write path does.
  always_comb begin
    nxt_flags = ((flags_ff & ~clr_vec) | set_vec) & HCIRQ_FLAGS_IMPL;
    if (!SMI_PRESENT) begin
      nxt_flags[HCIRQ_BIT_OWNER] = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flags_ff <= HCIRQ_FLAGS_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // Overrun tally counts every overrun reported at a frame copy update and wraps naturally at its width.
  // It counts even while the overrun flag is set, so software can spot
  // repeated overruns that a single flag bit would hide.
  always_comb begin
    nxt_tally = tally_ff;
    if (overrun_evt) begin
      nxt_tally = tally_ff + HCIRQ_TALLY_INC;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tally_ff <= HCIRQ_TALLY_RST;
    end else begin
      tally_ff <= nxt_tally;
    end
  end

  // Pending toggles and overruns wait for the frame copy update.
  // Several overruns before one copy update count as one; the schedule
  // can only overrun once per frame, so nothing real is lost.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wrap_pending_ff <= 1'b0;
      overrun_pending_ff <= 1'b0;
    end else begin
      wrap_pending_ff <= ~frame_copy_updated_i & (wrap_pending_ff | msb_toggle);
      overrun_pending_ff <= ~frame_copy_updated_i & (overrun_pending_ff | sched_overrun_i);
    end
  end

  // History of the sampled inputs for change and edge detection.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hub_global_last_ff <= '0;
      hub_port_last_ff <= '0;
      hub_primed_ff <= 1'b0;
      frame_msb_last_ff <= 1'b0;
      owner_req_last_ff <= 1'b0;
    end else begin
      hub_global_last_ff <= hub_global_state_i;
      hub_port_last_ff <= hub_port_state_i;
      hub_primed_ff <= 1'b1;
      frame_msb_last_ff <= frame_counter_i[HCIRQ_FRAME_MSB];
      owner_req_last_ff <= owner_switch_request_i;
    end
  end

  // Fatal error halt: processing stops on the error and resumes only
  // after a controller reset, whatever software does with the flag.
  always_comb begin
    nxt_halt_state = halt_state_ff;
    case (halt_state_ff)
      HCIRQ_RUN: begin
        if (fatal_evt) begin
          nxt_halt_state = HCIRQ_HALTED;
        end
      end
      HCIRQ_HALTED: begin
        if (hc_soft_reset_i) begin
          nxt_halt_state = HCIRQ_RECOVER;
        end
      end
      HCIRQ_RECOVER: begin
        // Stay halted while the error source is still asserted.
        if (fatal_evt) begin
          nxt_halt_state = HCIRQ_HALTED;
        end else if (!hc_soft_reset_i) begin
          nxt_halt_state = HCIRQ_RUN;
        end
      end
      default: begin
        nxt_halt_state = HCIRQ_HALTED;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      halt_state_ff <= HCIRQ_RUN;
    end else begin
      halt_state_ff <= nxt_halt_state;
    end
  end

  // Halt is combinational on the error so no further cycle slips through.
  assign proc_halt_o = fatal_evt | (halt_state_ff != HCIRQ_RUN);

  // A later write of the done pointer must wait for the flag to clear.
  // The list engine relies on this level and not on the interrupt.
  assign done_write_allow_o = ~flags_ff[HCIRQ_BIT_DONE];

  // Interrupt request: every set and enabled flag under the master gate, except the owner flag when a management pin is present.
  assign master_gate = irq_enable_mask_i[HCIRQ_BIT_GATE];
  assign pending_vec = flags_ff & irq_enable_mask_i & HCIRQ_FLAGS_IMPL;

  // With a management pin the owner flag is routed there instead.
  // Sending it to both lines would hand the driver an ownership
  // interrupt that it is not meant to service.
  always_comb begin
    irq_src_vec = pending_vec;
    if (SMI_PRESENT) begin
      irq_src_vec[HCIRQ_BIT_OWNER] = 1'b0;
    end
  end

  // Level request, drops as soon as nothing qualifying remains.
  assign irq_o = master_gate & (|irq_src_vec);

  // Owner flag goes to the management pin qualified only by its enable bit 30, not by the master gate.
  assign sys_mgmt_irq_pin_o = SMI_PRESENT & pending_vec[HCIRQ_BIT_OWNER];

  // Read data is registered; an unmapped offset reads as zero.
  // The word returned is the flag value before the edge of the read, so
  // an event in that same cycle shows up on the next read.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_ff <= HCIRQ_FLAGS_RST;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd_i;
      if (rd_flags) begin
        rdata_ff <= flags_ff;
      end else if (reg_rd_i) begin
        rdata_ff <= HCIRQ_FLAGS_RST;
      end
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;
  assign overrun_tally_o = tally_ff;
  assign irq_event_flags_o = flags_ff;

endmodule

// ===== bench/hcirq_flags_chk.sv
`timescale 1ns/1ns
module hcirq_flags_chk
  import hcirq_pkg::*;
#(
  parameter bit SMI_PRESENT = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [3:0] reg_be_i,
  input wire logic [31:0] reg_wdata_i,
  // Events and mask
  input wire logic [31:0] irq_enable_mask_i,
  input wire logic owner_switch_request_i,
  input wire logic frame_copy_updated_i,
  input wire logic sof_token_i,
  input wire logic done_pointer_written_i,
  input wire logic sys_error_i,
  // Outputs
  input wire logic done_write_allow_o,
  input wire logic proc_halt_o,
  input wire logic [1:0] overrun_tally_o,
  input wire logic [31:0] irq_event_flags_o,
  input wire logic irq_o,
  input wire logic sys_mgmt_irq_pin_o
);
  logic [31:0] keep;
  logic [31:0] held;
  logic hit;
  assign hit = reg_wr_i && (reg_addr_i == HCIRQ_OFS_FLAGS);
  assign keep = ~(reg_wdata_i & {{8{reg_be_i[3]}}, {8{reg_be_i[2]}}, {8{reg_be_i[1]}},
    {8{reg_be_i[0]}}} & {32{hit}});
  assign held = irq_event_flags_o & keep;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_irq_level: assert property (irq_o == (irq_enable_mask_i[31] &&
    |(irq_event_flags_o[6:0] & irq_enable_mask_i[6:0])))
    else $error("irq level mismatch");
  a_smi_owner: assert property (sys_mgmt_irq_pin_o ==
    (SMI_PRESENT && irq_event_flags_o[30] && irq_enable_mask_i[30]))
    else $error("smi level mismatch");
  a_owner_set: assert property ($rose(owner_switch_request_i) |=>
    irq_event_flags_o[30] == SMI_PRESENT) else $error("owner flag wrong");
  a_sof_sets: assert property (sof_token_i |=> irq_event_flags_o[2])
    else $error("frame begin flag missing");
  a_done_sets: assert property (done_pointer_written_i |=> irq_event_flags_o[1])
    else $error("done flag missing");
  a_done_gate: assert property (done_write_allow_o == !irq_event_flags_o[1])
    else $error("done write allowed while flagged");
  a_error_halt: assert property (sys_error_i |-> proc_halt_o ##1 irq_event_flags_o[4])
    else $error("error did not halt or flag");
  a_no_self_clr: assert property (1'b1 |=>
    ((irq_event_flags_o & $past(held)) == $past(held))) else $error("flag lost");
  a_reserved_zero: assert property ((irq_event_flags_o & ~HCIRQ_FLAGS_IMPL) == 32'h0)
    else $error("reserved flag bit set");
  a_copy_cause: assert property (($rose(irq_event_flags_o[5]) ||
    $rose(irq_event_flags_o[0])) |-> $past(frame_copy_updated_i))
    else $error("wrap or overrun without copy update");
  a_tally_step: assert property ((overrun_tally_o != $past(overrun_tally_o)) |->
    (overrun_tally_o == $past(overrun_tally_o) + 2'h1) && $past(frame_copy_updated_i))
    else $error("tally step wrong");
endmodule

bind hcirq_flags hcirq_flags_chk #(.SMI_PRESENT(SMI_PRESENT)) u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_be_i(reg_be_i), .reg_wdata_i(reg_wdata_i), .irq_enable_mask_i(irq_enable_mask_i),
  .owner_switch_request_i(owner_switch_request_i), .frame_copy_updated_i(frame_copy_updated_i),
  .sof_token_i(sof_token_i), .done_pointer_written_i(done_pointer_written_i),
  .sys_error_i(sys_error_i), .done_write_allow_o(done_write_allow_o), .proc_halt_o(proc_halt_o),
  .overrun_tally_o(overrun_tally_o), .irq_event_flags_o(irq_event_flags_o), .irq_o(irq_o),
  .sys_mgmt_irq_pin_o(sys_mgmt_irq_pin_o)
);

// ===== bench/hcirq_host.sv
`timescale 1ns/1ns
module hcirq_host
  import hcirq_pkg::*;
(
  // Clock and read answer
  input wire logic clk_i,
  input wire logic reg_rvalid_i,
  input wire logic [31:0] reg_rdata_i,
  // Register port
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [3:0] reg_be_o,
  output logic [31:0] reg_wdata_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_be_o = 4'h0;
    reg_wdata_o = 32'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_be_o <= b;
    reg_wdata_o <= d & HCIRQ_FLAGS_IMPL;
    reg_wr_o <= 1'b1;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    // Released data lines flip so a stale value can never pass for a real one.
    reg_wdata_o <= ~(d & HCIRQ_FLAGS_IMPL);
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output bit ok);
    ok = 1'b0;
    d = 32'hFFFF_FFFF;
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk_i);
      if (reg_rvalid_i === 1'b1) begin
        ok = 1'b1;
        d = reg_rdata_i;
      end
    end
  endtask
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ns
module tb;
  import hcirq_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr;
  logic [3:0] be, b;
  logic [31:0] wdata, rdata, mask, hubg, flags, expf, rv, w;
  logic [63:0] hubp;
  logic [15:0] fcnt;
  logic wr, rd, rvalid, own, hsr, cpy, sof, ovr, done, serr, wpin, wst, hubt;
  logic allow, halt, irq, smi, smi0;
  logic [31:0] flags0;
  logic [1:0] tally, nov;
  int errors = 0;
  int total_checks = 0;
  int k;
  bit ok;
  initial forever #2 clk_i = ~clk_i;
  hcirq_flags #(.SMI_PRESENT(1'b1)) u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_be_i(be), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .irq_enable_mask_i(mask), .owner_switch_request_i(own), .hc_soft_reset_i(hsr),
    .hub_global_state_i(hubg), .hub_port_state_i(hubp), .frame_counter_i(fcnt),
    .frame_copy_updated_i(cpy), .sof_token_i(sof), .sched_overrun_i(ovr),
    .done_pointer_written_i(done), .done_write_allow_o(allow), .sys_error_i(serr),
    .wake_signal_pin_i(wpin), .wake_signaling_state_i(wst), .proc_halt_o(halt),
    .overrun_tally_o(tally), .irq_event_flags_o(flags), .irq_o(irq), .sys_mgmt_irq_pin_o(smi)
  );
  hcirq_flags #(.SMI_PRESENT(1'b0)) u_dut_nosmi (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_be_i(be), .reg_wdata_i(wdata), .reg_rdata_o(), .reg_rvalid_o(),
    .irq_enable_mask_i(mask), .owner_switch_request_i(own), .hc_soft_reset_i(hsr),
    .hub_global_state_i(hubg), .hub_port_state_i(hubp), .frame_counter_i(fcnt),
    .frame_copy_updated_i(cpy), .sof_token_i(sof), .sched_overrun_i(ovr),
    .done_pointer_written_i(done), .done_write_allow_o(), .sys_error_i(serr),
    .wake_signal_pin_i(wpin), .wake_signaling_state_i(wst), .proc_halt_o(),
    .overrun_tally_o(), .irq_event_flags_o(flags0), .irq_o(), .sys_mgmt_irq_pin_o(smi0)
  );
  hcirq_host u_host (
    .clk_i(clk_i), .reg_rvalid_i(rvalid), .reg_rdata_i(rdata), .reg_addr_o(addr),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_be_o(be), .reg_wdata_o(wdata)
  );
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    u_host.rd(a, rv, ok);
    if (!ok) begin
      errors++;
      $display("unexpected at %0t: no read answer", $time);
      print_verdict();
    end
    chk(rv, exp);
  endtask
  function automatic logic [31:0] ev_bits(input int n);
    logic [31:0] t [8] = '{32'h4, 32'h2, 32'h10, 32'h4000_0000, 32'h0, 32'h21, 32'h40, 32'h8};
    ev_bits = t[n];
  endfunction
  function automatic logic [31:0] lanes(input logic [3:0] m);
    lanes = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction
  function automatic logic [31:0] pins(input logic [31:0] f, input logic [31:0] m);
    pins = {29'h0, m[31] & (|(f[6:0] & m[6:0])), f[30] & m[30], ~f[1]};
  endfunction
  task automatic ev(input int n);
    @(posedge clk_i);
    {wpin, hubt, ovr, hsr, own, serr, done, sof} <= 8'h01 << n;
    cpy <= (n == 5);
    if (n == 5) fcnt <= fcnt ^ 16'h8000;
    if (n == 6 && $urandom_range(1)) hubg <= hubg ^ ($urandom | 32'h1);
    else if (n == 6) hubp <= hubp ^ {$urandom, $urandom | 32'h1};
    @(posedge clk_i);
    {wpin, hubt, ovr, hsr, own, serr, done, sof} <= 8'h00;
    cpy <= 1'b0;
    repeat (4) @(posedge clk_i);
    if (n == 5) nov = nov + 2'h1;
    if (!(wst && n == 7)) expf = expf | ev_bits(n);
  endtask
  initial begin
    {own, hsr, cpy, sof, ovr, done, serr, wpin, wst, hubt} = 10'h0;
    mask = 32'hC000_007F;
    hubg = 32'h0;
    hubp = 64'h0;
    fcnt = 16'h0;
    expf = 32'h0;
    nov = 2'h0;
    void'($urandom(32'hF2A611E9));
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rdc(HCIRQ_OFS_FLAGS, HCIRQ_FLAGS_RST);
    u_host.wr(HCIRQ_OFS_FLAGS, 4'hF, 32'hFFFF_FFFF);
    chk(flags, 32'h0);
    for (int n = 0; n < 8; n++) begin
      if (n != 4) ev(n);
      chk(flags, expf);
    end
    chk({31'h0, halt}, 32'h1);
    chk(flags0, expf & ~32'h4000_0000);
    rdc(HCIRQ_OFS_FLAGS, expf);
    u_host.wr(HCIRQ_OFS_FLAGS, 4'hF, 32'h0);
    chk(flags, expf);
    u_host.wr(8'h10, 4'hF, 32'hFFFF_FFFF);
    chk(flags, expf);
    rdc(8'h10, 32'h0);
    ev(4);
    chk({31'h0, halt}, 32'h0);
    for (int n = 0; n < 4; n++) begin
      ev(5);
      chk({30'h0, tally}, {30'h0, nov});
    end
    u_host.wr(HCIRQ_OFS_FLAGS, 4'hF, 32'hFFFF_FFFF);
    expf = 32'h0;
    @(posedge clk_i);
    wst <= 1'b1;
    ev(7);
    chk(flags, 32'h0);
    wst <= 1'b0;
    repeat (40) begin
      k = $urandom_range(7);
      if (k == 2 || k == 4) k = 1;
      @(posedge clk_i);
      mask <= $urandom;
      ev(k);
      b = 4'($urandom);
      w = $urandom;
      u_host.wr(HCIRQ_OFS_FLAGS, b, w);
      expf = expf & ~(w & HCIRQ_FLAGS_IMPL & lanes(b));
      chk(flags, expf);
      chk({29'h0, irq, smi, allow}, pins(expf, mask));
      chk({smi0, flags0[30:0]}, {1'b0, 31'h3FFF_FFFF & expf[30:0]});
    end
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk(flags, 32'h0);
    chk({30'h0, tally}, 32'h0);
    print_verdict();
  end
endmodule
